//--- src/lsau_map.vh
// Constants for the load/store address unit: operation codes, sizes,
// condition codes and flag positions.
// Assumes inclusion by lsau_top.v only.
`ifndef LSAU_MAP_VH
`define LSAU_MAP_VH
// Operation codes
`define LSAU_OP_WORD_LOAD      4'h0
`define LSAU_OP_BYTE_LOAD_ZEXT 4'h1
`define LSAU_OP_HALF_LOAD_ZEXT 4'h2
`define LSAU_OP_BYTE_LOAD_SEXT 4'h3
`define LSAU_OP_HALF_LOAD_SEXT 4'h4
`define LSAU_OP_WORD_STORE     4'h5
`define LSAU_OP_BYTE_STORE     4'h6
`define LSAU_OP_HALF_STORE     4'h7
`define LSAU_OP_PC_ADDR        4'h8
`define LSAU_OP_PC_LOAD        4'h9
`define LSAU_OP_BRANCH         4'ha
// Address modes
`define LSAU_MODE_IMM_BASE     2'h0
`define LSAU_MODE_IMM_STACK    2'h1
`define LSAU_MODE_REG_OFFSET   2'h2
// Condition codes
`define LSAU_COND_EQ           4'h0
`define LSAU_COND_NE           4'h1
`define LSAU_COND_CS           4'h2
`define LSAU_COND_CC           4'h3
`define LSAU_COND_MI           4'h4
`define LSAU_COND_PL           4'h5
`define LSAU_COND_VS           4'h6
`define LSAU_COND_VC           4'h7
`define LSAU_COND_HI           4'h8
`define LSAU_COND_LOWER_SAME   4'h9
`define LSAU_COND_AT_LEAST     4'ha
`define LSAU_COND_BELOW        4'hb
`define LSAU_COND_ABOVE        4'hc
`define LSAU_COND_AT_MOST      4'hd
`define LSAU_COND_EVERY_TIME   4'he
// Flag bit positions within program_status_flags
`define LSAU_FLAG_N            3
`define LSAU_FLAG_Z            2
`define LSAU_FLAG_C            1
`define LSAU_FLAG_V            0
// Byte strobes
`define LSAU_BYTE_STORE_WORD         4'hf
`define LSAU_BYTE_STORE_HALF         4'h3
`define LSAU_BYTE_STORE_BYTE         4'h1
`define LSAU_BYTE_STORE_NONE         4'h0
// States
`define LSAU_ST_IDLE           2'h0
`define LSAU_ST_WAIT           2'h1
`endif

//--- src/lsau_top.v
// Load/store address unit: address forming, access sizing, data extension
// and branch condition evaluation for a 32-bit core.
// Assumes memory answers with mem_rvalid some cycles after a read request.
//
// Summary of operation
// [RULE1] Branch taken only when flags meet condition, else no effect; the code still loads branch_target_q on a failed condition.
// [RULE2] Decode lower-or-same and signed compare conditions from N, Z, C, V.
// [RULE3] Always condition is true whatever the flags; used without suffix.
// [RULE4] PC-relative address: program counter plus immediate to destination.
// [RULE5] Software: low destination, aligned target within 1020 bytes.
// [RULE6] Software sets bit 0 of addresses used for branch with exchange.
// [RULE7] Address and single load/store leave the status flags unchanged.
// [RULE8] Immediate byte and halfword loads are zero-filled to 32 bits.
// [RULE9] Stores write word, lowest byte or lower halfword by size.
// [RULE10] Immediate address is base or stack pointer plus immediate.
// [RULE11] Software keeps immediate offsets within their encoded ranges.
// [RULE12] Software names only low eight registers for transfer and base.
// [RULE13] Software keeps computed addresses aligned to the access size.
// [RULE14] Register-offset address is base plus offset register contents.
// [RULE15] Register-offset loads: word, zero or sign extended byte/halfword.
// [RULE16] PC-relative load reads one word into the transfer register.
// [RULE17] Software keeps the literal label word aligned within 1020 bytes.
// [RULE18] Misaligned access is aborted and raises a fault, no transfer.
`timescale 1ns/1ps
`default_nettype none
`include "lsau_map.vh"

module lsau_top #(
   parameter DW = 32
) (
   // Clock, reset, enable
   input  wire          clk_sys,
   input  wire          rst,
   input  wire          clk_en,
   // Instruction request
   input  wire          op_valid,
   input  wire [3:0]    op_code,
   input  wire [1:0]    addr_mode,
   input  wire [3:0]    cond_code,
   input  wire [DW-1:0] base_reg,
   input  wire [DW-1:0] offset_reg,
   input  wire [DW-1:0] stack_ptr,
   input  wire [DW-1:0] program_counter,
   input  wire [DW-1:0] imm_value,
   input  wire [DW-1:0] transfer_reg,
   input  wire [3:0]    program_status_flags,
   // Memory side
   output reg           mem_req_q,
   output reg           mem_we_q,
   output reg  [DW-1:0] mem_addr_q,
   output reg  [DW-1:0] mem_wdata_q,
   output reg  [3:0]    mem_byte_store_q,
   input  wire          mem_rvalid,
   input  wire [DW-1:0] mem_rdata,
   // Results
   output reg           busy_q,
   output reg           wr_en_q,
   output reg  [DW-1:0] wr_data_q,
   output reg           branch_taken_q,
   output reg  [DW-1:0] branch_target_q,
   output reg           fault_q,
   output reg  [3:0]    flags_out_q
);

   // ======================================================================
   // Condition evaluation
   wire fn = program_status_flags[`LSAU_FLAG_N];
   wire fz = program_status_flags[`LSAU_FLAG_Z];
   wire fc = program_status_flags[`LSAU_FLAG_C];
   wire fv = program_status_flags[`LSAU_FLAG_V];
   reg  cond_pass;

   // Unknown codes fail safe: branch not taken
   always @* begin
      case (cond_code)
         `LSAU_COND_EQ:         cond_pass = fz;
         `LSAU_COND_NE:         cond_pass = ~fz;
         `LSAU_COND_CS:         cond_pass = fc;
         `LSAU_COND_CC:         cond_pass = ~fc;
         `LSAU_COND_MI:         cond_pass = fn;
         `LSAU_COND_PL:         cond_pass = ~fn;
         `LSAU_COND_VS:         cond_pass = fv;
         `LSAU_COND_VC:         cond_pass = ~fv;
         `LSAU_COND_HI:         cond_pass = fc & ~fz;
         `LSAU_COND_LOWER_SAME: cond_pass = ~fc | fz;          // RULE2
         `LSAU_COND_AT_LEAST:   cond_pass = (fn == fv);        // RULE2
         `LSAU_COND_BELOW:      cond_pass = (fn != fv);        // RULE2
         `LSAU_COND_ABOVE:      cond_pass = ~fz & (fn == fv);  // RULE2
         `LSAU_COND_AT_MOST:    cond_pass = fz | (fn != fv);   // RULE2
         `LSAU_COND_EVERY_TIME: cond_pass = 1'b1;              // RULE3
         default:               cond_pass = 1'b0;
      endcase
   end

   // ======================================================================
   // Address forming
   reg [DW-1:0] ea;
   always @* begin
      case (addr_mode)
         `LSAU_MODE_IMM_STACK:  ea = stack_ptr + imm_value;    // RULE10
         `LSAU_MODE_REG_OFFSET: ea = base_reg + offset_reg;    // RULE14
         default:               ea = base_reg + imm_value;     // RULE10
      endcase
   end
   wire [DW-1:0] pc_sum = program_counter + imm_value;          // RULE4

   // Access size and store strobes
   reg [3:0] byte_store;
   reg       is_load;
   reg       is_store;
   always @* begin
      is_load  = 1'b0;
      is_store = 1'b0;
      byte_store     = `LSAU_BYTE_STORE_NONE;
      case (op_code)
         `LSAU_OP_WORD_LOAD, `LSAU_OP_PC_LOAD: begin
            is_load = 1'b1;
            byte_store    = `LSAU_BYTE_STORE_WORD;
         end
         `LSAU_OP_HALF_LOAD_ZEXT, `LSAU_OP_HALF_LOAD_SEXT: begin
            is_load = 1'b1;
            byte_store    = `LSAU_BYTE_STORE_HALF;
         end
         `LSAU_OP_BYTE_LOAD_ZEXT, `LSAU_OP_BYTE_LOAD_SEXT: begin
            is_load = 1'b1;
            byte_store    = `LSAU_BYTE_STORE_BYTE;
         end
         `LSAU_OP_WORD_STORE: begin
            is_store = 1'b1;
            byte_store     = `LSAU_BYTE_STORE_WORD;                         // RULE9
         end
         `LSAU_OP_HALF_STORE: begin
            is_store = 1'b1;
            byte_store     = `LSAU_BYTE_STORE_HALF;                         // RULE9
         end
         `LSAU_OP_BYTE_STORE: begin
            is_store = 1'b1;
            byte_store     = `LSAU_BYTE_STORE_BYTE;                         // RULE9
         end
         default: begin
            is_load  = 1'b0;
            is_store = 1'b0;
         end
      endcase
   end

   // Literal loads use the program counter sum, others the formed address
   wire [DW-1:0] acc_addr = (op_code == `LSAU_OP_PC_LOAD) ? pc_sum : ea;
   // Misaligned access detection, checked before any bus request
   wire misalign = (byte_store == `LSAU_BYTE_STORE_WORD) ? (acc_addr[1:0] != 2'h0) :
                   (byte_store == `LSAU_BYTE_STORE_HALF) ? acc_addr[0] : 1'b0;

   // ======================================================================
   // Load data extension, using the operation latched at request time
   reg [3:0]    pend_op_q;
   reg [DW-1:0] ld_ext;
   always @* begin
      case (pend_op_q)
         `LSAU_OP_BYTE_LOAD_ZEXT:
            ld_ext = {{(DW-8){1'b0}}, mem_rdata[7:0]};        // RULE8 RULE15
         `LSAU_OP_HALF_LOAD_ZEXT:
            ld_ext = {{(DW-16){1'b0}}, mem_rdata[15:0]};      // RULE8 RULE15
         `LSAU_OP_BYTE_LOAD_SEXT:
            ld_ext = {{(DW-8){mem_rdata[7]}}, mem_rdata[7:0]};     // RULE15
         `LSAU_OP_HALF_LOAD_SEXT:
            ld_ext = {{(DW-16){mem_rdata[15]}}, mem_rdata[15:0]};  // RULE15
         default:
            ld_ext = mem_rdata;                                // RULE16
      endcase
   end

   // ======================================================================
   // Control: one access outstanding; stores finish in one cycle
   reg [1:0] state_q;
   always @(posedge clk_sys) begin
      if (rst) begin
         state_q         <= `LSAU_ST_IDLE;
         pend_op_q       <= `LSAU_OP_WORD_LOAD;
         mem_req_q       <= 1'b0;
         mem_we_q        <= 1'b0;
         mem_addr_q      <= {DW{1'b0}};
         mem_wdata_q     <= {DW{1'b0}};
         mem_byte_store_q      <= `LSAU_BYTE_STORE_NONE;
         busy_q          <= 1'b0;
         wr_en_q         <= 1'b0;
         wr_data_q       <= {DW{1'b0}};
         branch_taken_q  <= 1'b0;
         branch_target_q <= {DW{1'b0}};
         fault_q         <= 1'b0;
         flags_out_q     <= 4'h0;
      end else if (clk_en) begin
         mem_req_q      <= 1'b0;
         wr_en_q        <= 1'b0;
         branch_taken_q <= 1'b0;
         fault_q        <= 1'b0;
         // Flags pass through untouched by every operation here
         flags_out_q    <= program_status_flags;               // RULE7
         case (state_q)
            `LSAU_ST_IDLE: begin
               if (op_valid) begin
                  if (op_code == `LSAU_OP_PC_ADDR) begin
                     wr_en_q   <= 1'b1;                        // RULE4
                     wr_data_q <= pc_sum;
                  end else if (op_code == `LSAU_OP_BRANCH) begin
                     // Failed condition leaves branch_taken_q low; branch_target_q is still loaded
                     branch_taken_q  <= cond_pass;             // RULE1
                     branch_target_q <= pc_sum;
                  end else if ((is_load | is_store) & misalign) begin
                     fault_q <= 1'b1;                          // RULE18
                  end else if (is_load | is_store) begin
                     mem_req_q   <= 1'b1;
                     mem_we_q    <= is_store;
                     mem_addr_q  <= acc_addr;
                     mem_byte_store_q  <= byte_store;
                     mem_wdata_q <= transfer_reg;              // RULE9
                     pend_op_q   <= op_code;
                     if (is_load) begin
                        state_q <= `LSAU_ST_WAIT;
                        busy_q  <= 1'b1;
                     end
                  end
               end
            end
            `LSAU_ST_WAIT: begin
               if (mem_rvalid) begin
                  wr_en_q   <= 1'b1;
                  wr_data_q <= ld_ext;                         // RULE8 RULE15
                  busy_q    <= 1'b0;
                  state_q   <= `LSAU_ST_IDLE;
               end
            end
            default: begin
               state_q <= `LSAU_ST_IDLE;
               busy_q  <= 1'b0;
            end
         endcase
      end
   end

endmodule // lsau_top
`default_nettype wire

//--- verification/lsau_chk_assertions.sv
// Port checker for lsau_top, bound onto every instance.
// Assumes one clock domain, clk_sys, with synchronous reset rst.
`timescale 1ns/1ps
`default_nettype none
module lsau_chk (
   // Clock, reset and request side
   input wire logic       clk_sys, rst, clk_en, op_valid, mem_rvalid,
   input wire logic [3:0] op_code, cond_code, program_status_flags,
   // Outputs watched
   input wire logic       mem_req_q, mem_we_q, busy_q, wr_en_q,
   input wire logic       branch_taken_q, fault_q,
   input wire logic [3:0] mem_byte_store_q, flags_out_q
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic [3:0] t_op;
   // ==========
   // Op taken at this edge; f stands for none, as f is no op code
   assign t_op = (clk_en && op_valid && !busy_q) ? op_code : 4'hf;
   a_flags_pass:
      assert property ($past(clk_en) && !$past(rst) |->
         flags_out_q == $past(program_status_flags)) else $error("flags");
   a_always_taken:
      assert property (t_op == 4'ha && cond_code == 4'he |=> branch_taken_q)
         else $error("always branch lost");
   a_branch_cause:
      assert property (branch_taken_q |-> $past(t_op) == 4'ha)
         else $error("stray branch");
   a_byte_store:
      assert property (t_op == 4'h6 |=>
         mem_req_q && mem_we_q && mem_byte_store_q == 4'h1)
         else $error("byte lanes");
   a_word_store:
      assert property (t_op == 4'h5 |=>
         fault_q || mem_req_q && mem_byte_store_q == 4'hf) else $error("word lanes");
   a_fault_quiet:
      assert property (fault_q |-> !mem_req_q && !wr_en_q)
         else $error("fault with transfer");
   a_load_wait:
      assert property (t_op <= 4'h4 || t_op == 4'h9 |=>
         fault_q || busy_q && mem_req_q && !mem_we_q) else $error("no read");
   a_load_done:
      assert property (busy_q && mem_rvalid && clk_en |=> wr_en_q && !busy_q)
         else $error("load not finished");
   a_pc_addr:
      assert property (t_op == 4'h8 |=> wr_en_q && !mem_req_q)
         else $error("address result late");
   cover property (t_op == 4'ha ##1 branch_taken_q);
   cover property (busy_q && mem_rvalid);
   cover property (fault_q);
endmodule // lsau_chk
bind lsau_top lsau_chk u_lsau_chk (.clk_sys, .rst, .clk_en, .op_valid,
   .mem_rvalid, .op_code, .cond_code, .program_status_flags, .mem_req_q,
   .mem_we_q, .busy_q, .wr_en_q, .branch_taken_q, .fault_q, .mem_byte_store_q,
   .flags_out_q);
`default_nettype wire

//--- verification/lsau_mem_model.sv
// Data memory model answering lsau_top requests, 16 words.
// Assumes one read in flight; read delay in cycles set by lat.
`timescale 1ns/1ps
`default_nettype none
module lsau_mem_model (
   // Clock, reset, read delay
   input  wire logic        clk_sys, rst,
   input  wire logic [3:0]  lat,
   // Request and answer
   input  wire logic        mem_req_q, mem_we_q,
   input  wire logic [31:0] mem_addr_q, mem_wdata_q,
   input  wire logic [3:0]  mem_byte_store_q,
   output var  logic        mem_rvalid,
   output var  logic [31:0] mem_rdata
);
   logic [31:0] mem [16];
   logic [3:0]  cnt_q, idx_q;
   logic        pend_q;
   // ==========
   // Pattern with sign bits set in low byte and half
   initial for (int i = 0; i < 16; i++) mem[i] = 32'h7a0080f0 | 32'(i);
   // Read data toggles outside its valid cycle, so stale data never matches
   always @(posedge clk_sys) begin
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (rst) pend_q <= 1'b0;
      else if (mem_req_q && mem_we_q) begin
         for (int b = 0; b < 4; b++)
            if (mem_byte_store_q[b])
               mem[mem_addr_q[5:2]][8*b +: 8] <= mem_wdata_q[8*b +: 8];
      end else if (mem_req_q) begin
         pend_q <= 1'b1;
         cnt_q <= lat;
         idx_q <= mem_addr_q[5:2];
      end else if (pend_q && cnt_q == 4'h0) begin
         mem_rvalid <= 1'b1;
         pend_q <= 1'b0;
         mem_rdata <= mem[idx_q];
      end else if (pend_q) cnt_q <= cnt_q - 4'h1;
   end
endmodule // lsau_mem_model
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for lsau_top with the memory model.
// Assumes lsau_chk is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct {logic [3:0] op; logic [1:0] md;
                   logic [31:0] b, o, im, ea, res;} lsau_row_t;
   logic        clk_sys = 0, rst = 1, clk_en = 1, op_valid = 0;
   logic [1:0]  addr_mode = '0;
   logic [3:0]  op_code = '0, cond_code = 4'he, program_status_flags = 4'h9;
   logic [3:0]  lat = '0, mem_byte_store_q, flags_out_q;
   logic [31:0] base_reg = '0, offset_reg = '0, stack_ptr = '0, imm_value = '0;
   logic [31:0] program_counter = '0, transfer_reg = '0, wr_data_q;
   logic [31:0] mem_addr_q, mem_wdata_q, mem_rdata, branch_target_q;
   logic        mem_req_q, mem_we_q, mem_rvalid, busy_q, wr_en_q;
   logic        branch_taken_q, fault_q;
   int          n_fail = 0, samples_checked = 0;
   // Ordinary loads and address results; stack and pc sit at base+400/800
   lsau_row_t rows [10] = '{
      '{4'h0, 2'h0, 32'h20, 32'h100, 32'h4, 32'h24, 32'h7a0080f9},
      '{4'h1, 2'h0, 32'h20, 32'h100, 32'h1, 32'h21, 32'hf8},
      '{4'h2, 2'h3, 32'h20, 32'h100, 32'h2, 32'h22, 32'h80f8},
      '{4'h3, 2'h2, 32'h10, 32'h4, 32'h8, 32'h14, 32'hfffffff5},
      '{4'h4, 2'h2, 32'h30, 32'he, 32'h0, 32'h3e, 32'hffff80ff},
      '{4'h0, 2'h1, 32'h0, 32'h100, 32'h3c, 32'h43c, 32'h7a0080ff},
      '{4'h8, 2'h0, 32'h0, 32'h100, 32'h3e4, 32'h0, 32'hbe4},
      '{4'h9, 2'h0, 32'h0, 32'h100, 32'h8, 32'h808, 32'h7a0080f2},
      '{4'h0, 2'h2, 32'h40, 32'h4, 32'h0, 32'h44, 32'h7a0080f1},
      '{4'h2, 2'h0, 32'h20, 32'h0, 32'h1, 32'h21, 32'h0}};
   lsau_top u_lsau_top (.clk_sys, .rst, .clk_en, .op_valid, .op_code,
      .addr_mode, .cond_code, .base_reg, .offset_reg, .stack_ptr,
      .program_counter, .imm_value, .transfer_reg, .program_status_flags,
      .mem_req_q, .mem_we_q, .mem_addr_q, .mem_wdata_q, .mem_byte_store_q,
      .mem_rvalid, .mem_rdata, .busy_q, .wr_en_q, .wr_data_q,
      .branch_taken_q, .branch_target_q, .fault_q, .flags_out_q);
   lsau_mem_model u_lsau_mem_model (.clk_sys, .rst, .lat, .mem_req_q,
      .mem_we_q, .mem_addr_q, .mem_wdata_q, .mem_byte_store_q, .mem_rvalid,
      .mem_rdata);
   // ==========
   // Clock, 4 ns period
   initial forever #2 clk_sys = ~clk_sys;
   task automatic chk(input string nm, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   function automatic logic cond_ok(input logic [3:0] c, f);
      case (c)
         4'h0: cond_ok = f[2];
         4'h1: cond_ok = !f[2];
         4'h2: cond_ok = f[1];
         4'h3: cond_ok = !f[1];
         4'h4: cond_ok = f[3];
         4'h5: cond_ok = !f[3];
         4'h6: cond_ok = f[0];
         4'h7: cond_ok = !f[0];
         4'h8: cond_ok = f[1] && !f[2];
         4'h9: cond_ok = !f[1] || f[2];
         4'ha: cond_ok = f[3] == f[0];
         4'hb: cond_ok = f[3] != f[0];
         4'hc: cond_ok = !f[2] && f[3] == f[0];
         4'hd: cond_ok = f[2] || f[3] != f[0];
         4'he: cond_ok = 1'b1;
         default: cond_ok = 1'b0;
      endcase
   endfunction
   // One op: one-cycle request, results looked at one cycle later
   task automatic run(input lsau_row_t r);
      int k;
      logic f;
      @(negedge clk_sys);
      {op_valid, op_code, addr_mode} = {1'b1, r.op, r.md};
      {base_reg, offset_reg} = {r.b, r.o};
      {imm_value, transfer_reg} = {r.im, r.res};
      stack_ptr = r.b + 32'h400;
      program_counter = r.b + 32'h800;
      @(negedge clk_sys);
      op_valid = 1'b0;
      k = 0;
      f = (r.op inside {4'h0, 4'h5, 4'h9} && r.ea[1:0] != 2'h0) ||
          (r.op inside {4'h2, 4'h4, 4'h7} && r.ea[0]);
      chk("flags", 32'(program_status_flags), 32'(flags_out_q));
      if (r.op == 4'ha) begin
         chk("taken", r.res, {31'h0, branch_taken_q});
         chk("target", r.b + 32'h800 + r.im, branch_target_q);
      end else if (r.op == 4'h8) chk("pc sum", r.res, wr_data_q);
      else begin
         chk("fault", {31'h0, f}, {31'h0, fault_q});
         if (!f) chk("address", r.ea, mem_addr_q);
         if (!f && (r.op < 4'h5 || r.op == 4'h9)) begin
            while (wr_en_q !== 1'b1 && k < 40) begin
               @(negedge clk_sys);
               k++;
            end
            chk("load data", r.res, wr_data_q);
         end
      end
   endtask
   // Watchdog far beyond the seven hundred or so cycles the run needs
   initial begin
      repeat (5000) @(posedge clk_sys);
      n_fail++;
      wrap_up;
   end
   initial begin
      repeat (16) @(negedge clk_sys);
      rst = 1'b0;
      chk("reset outs", 32'h0, {28'h0, busy_q, wr_en_q, mem_req_q, fault_q});
      // Prompt memory first, then slow memory
      for (int p = 0; p < 2; p++) begin
         lat = p ? 4'h6 : 4'h0;
         foreach (rows[i]) run(rows[i]);
      end
      // Narrow stores back to back with read-back, then word stores
      run('{4'h6, 2'h0, 32'h20, 32'h0, 32'h4, 32'h24, 32'h11223344});
      run('{4'h0, 2'h0, 32'h24, 32'h0, 32'h0, 32'h24, 32'h7a008044});
      run('{4'h7, 2'h2, 32'h20, 32'h4, 32'h0, 32'h24, 32'haabb5566});
      run('{4'h0, 2'h0, 32'h24, 32'h0, 32'h0, 32'h24, 32'h7a005566});
      run('{4'h5, 2'h0, 32'h20, 32'h0, 32'h8, 32'h28, 32'h0});
      run('{4'h5, 2'h0, 32'h20, 32'h0, 32'h6, 32'h26, 32'h0});
      // Enable low: request not taken, outputs hold their last values
      @(negedge clk_sys);
      clk_en = 1'b0;
      {op_valid, op_code} = {1'b1, 4'h8};
      imm_value = 32'h4;
      repeat (3) @(negedge clk_sys);
      chk("frozen wr_en", 32'h0, {31'h0, wr_en_q});
      chk("frozen data", 32'h7a005566, wr_data_q);
      clk_en = 1'b1;
      op_valid = 1'b0;
      // Reset in the middle of a slow load must clear the wait
      lat = 4'h6;
      @(negedge clk_sys);
      {op_valid, op_code, addr_mode} = {1'b1, 4'h0, 2'h0};
      @(negedge clk_sys);
      op_valid = 1'b0;
      rst = 1'b1;
      @(negedge clk_sys);
      rst = 1'b0;
      chk("reset busy", 32'h0, {30'h0, busy_q, mem_req_q});
      // Every flag pattern against every condition code
      for (int c = 0; c < 16; c++)
         for (int f = 0; f < 16; f++) begin
            cond_code = c[3:0];
            program_status_flags = f[3:0];
            run('{4'ha, 2'h0, 32'h0, 32'h0, 32'h10, 32'h0,
                  {31'h0, cond_ok(c[3:0], f[3:0])}});
         end
      wrap_up;
   end
endmodule // tb_top
`default_nettype wire
